// *** inc/fts_pkg.sv ***
// Purpose: Shared constants and types of the failure transfer supervisor
// Assumes: 32-bit register words, byte addresses in steps of four
// Notes: Percent levels are in 0.1 % units, 0 to 1000
package fts_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int POWERUP_MS = 2500;
  localparam int POWERUP_CYCLES = POWERUP_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INCFG = 8'h04;
  localparam logic [7:0] OFS_OUT1 = 8'h08;
  localparam logic [7:0] OFS_SECOND_OUTPUT_FUNCTION = 8'h0c;
  localparam logic [7:0] OFS_ALM1 = 8'h10;
  localparam logic [7:0] OFS_ALM2 = 8'h14;
  localparam logic [7:0] OFS_SPLIM = 8'h18;
  localparam logic [7:0] OFS_SP = 8'h1c;
  localparam logic [7:0] OFS_SHIFT = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_PV1 = 8'h28;
  localparam logic [7:0] OFS_MVAVG = 8'h2c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_MANUAL_BIT = 0;
  localparam int CTRL_CALIB_BIT = 1;
  localparam int CTRL_LCLR_BIT = 2;
  localparam int IN_PVSEL_LSB = 0;
  localparam int IN_SPSEL_LSB = 2;
  localparam int IN_RNG1_LSB = 4;
  localparam int IN_RNG2_LSB = 6;
  localparam int OUT_FAIL_LSB = 0;
  localparam int OUT_MODE_BIT = 12;
  localparam int OUT_PB_LSB = 16;
  localparam int ALM_FN_LSB = 0;
  localparam int ALM_BEH_LSB = 4;
  localparam int ALM_FT_BIT = 8;
  localparam int LIM_LOW_LSB = 0;
  localparam int LIM_HIGH_LSB = 16;
  localparam int PCT_W = 11;

  // ----------------------------------------
  // Levels and reset values
  // ----------------------------------------
  localparam logic [10:0] PCT_MAX = 11'h3e8;
  localparam logic [10:0] FAIL_BUMPLESS = 11'h7ff;
  localparam logic [15:0] BREAK_UA = 16'h03e8;
  localparam logic [15:0] BREAK_MV = 16'h00fa;
  localparam logic [31:0] RST_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_SPLIM = 32'h7fff_8000;
  localparam logic [15:0] RST_SP = 16'h0000;
  localparam logic [15:0] RST_SHIFT = 16'h0000;
  localparam int AVG_SHIFT = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {PVS_ONE = 2'h0, PVS_TWO = 2'h1, PVS_DIFF12 = 2'h2,
                            PVS_DIFF21 = 2'h3} fts_pvsel_t;
  typedef enum logic [1:0] {SPS_LOCAL = 2'h0, SPS_ONE = 2'h1,
                            SPS_TWO = 2'h2} fts_spsel_t;
  typedef enum logic [1:0] {RNG_SENSOR = 2'h0, RNG_MA = 2'h1,
                            RNG_VOLT = 2'h2} fts_range_t;
  typedef enum logic [3:0] {AF_PROCESS = 4'h0, AF_LOOP = 4'h1, AF_SENSOR = 4'h2,
                            AF_DWELL = 4'h3} fts_afn_t;
  typedef enum logic [1:0] {AB_NORMAL = 2'h0, AB_LATCH = 2'h1, AB_HOLD = 2'h2,
                            AB_LTHOLD = 2'h3} fts_abeh_t;
  typedef enum logic [2:0] {ST_STARTUP = 3'b001, ST_RUN = 3'b010,
                            ST_TRANSFER = 3'b100} fts_state_t;
endpackage

// *** rtl/fts_mv_average.sv ***
// Purpose: Running average of one manipulated value
// Assumes: Samples arrive as one-cycle take pulses
// Notes: Exponential average, weight one eighth per sample
`timescale 1ns/1ps
module fts_mv_average
  import fts_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic take_i,
  input wire logic [10:0] sample_i,
  output logic [10:0] avg_o
);
  logic [13:0] acc;
  logic [13:0] next_acc;
  logic [14:0] sum;

  always_comb
  begin
    // Wide sum, steady state stays below 14 bits for 11-bit samples
    sum = 15'(acc) - 15'(acc >> AVG_SHIFT) + 15'(sample_i);
    next_acc = acc;
    if (take_i)
    begin
      next_acc = sum[13:0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acc <= 14'h0000;
    end
    else
    begin
      acc <= next_acc;
    end
  end

  assign avg_o = acc[13:3];
endmodule

// *** rtl/fts_supervisor.sv ***
// Purpose: Failure detection, output and alarm failure transfer, setpoint clamp
// Assumes: All inputs synchronous to CLK_I; PID and alarm compare logic outside
// Notes: Register reads answer one cycle after the read strobe
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module fts_supervisor
  import fts_pkg::*;
#(
  parameter int unsigned POWERUP_LEN = POWERUP_CYCLES
)
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic IN1_BREAK_I,
  input wire logic [15:0] IN1_SIGNAL_I,
  input wire logic IN2_BREAK_I,
  input wire logic [15:0] IN2_SIGNAL_I,
  input wire logic ADC_FAIL_I,
  input wire logic [15:0] PV1_RAW_I,
  input wire logic [10:0] MV1_I,
  input wire logic [10:0] MV2_I,
  input wire logic MV_STROBE_I,
  input wire logic ONOFF_DEMAND_I,
  input wire logic ALARM1_COND_I,
  input wire logic ALARM2_COND_I,
  input wire logic SP_REACHED_I,
  input wire logic EVENT_CLEAR_I,
  output logic [10:0] OUT1_LEVEL_O,
  output logic OUT1_ON_O,
  output logic [10:0] SECOND_OUTPUT_FUNCTION_LEVEL_O,
  output logic ALARM1_O,
  output logic ALARM2_O,
  output logic FAIL_MODE_O,
  output logic TRANSFER_O,
  output logic [15:0] SETPOINT_O,
  output logic [15:0] PV1_O,
  output logic HIDE1_O,
  output logic HIDE2_O
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic in_break(input logic brk, input logic [1:0] rng,
                                    input logic [15:0] sig);
    in_break = brk || (rng == RNG_MA && sig < BREAK_UA)
               || (rng == RNG_VOLT && sig < BREAK_MV);
  endfunction

  function automatic logic [10:0] pct_clamp(input logic [10:0] v);
    pct_clamp = (v > PCT_MAX) ? PCT_MAX : v;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl, incfg, o1cfg, o2cfg, splim;
  logic [31:0] next_ctrl, next_incfg, next_o1cfg, next_o2cfg, next_splim;
  logic [8:0] acfg [2];
  logic [8:0] next_acfg [2];
  logic [15:0] sp_req, shift_val, next_sp_req, next_shift_val;
  logic [31:0] next_rdata;
  logic lclr_c;

  // ----------------------------------------
  // Supervisor state
  // ----------------------------------------
  fts_state_t state, next_state;
  logic [31:0] pu_cnt, next_pu_cnt;
  logic brk1_c, brk2_c, fail_c, use1_c, use2_c;
  logic brk1, brk2, aderr, next_brk1, next_brk2, next_aderr;
  logic next_fail, next_xfer;

  // ----------------------------------------
  // Outputs and alarms
  // ----------------------------------------
  logic [10:0] avg1, avg2, next_lvl1, next_lvl2;
  logic next_on1;
  logic [15:0] next_sp, next_pv1;
  logic [16:0] pv_sum;
  logic [1:0] armed, latched, alm, hide, next_armed, next_latched;
  logic [1:0] next_alm, next_hide, cond_c;
  logic [3:0] afn [2];
  logic [1:0] abeh [2];
  logic raw_c [2];
  logic eff_c [2];
  logic holdon_c [2];
  logic latching_c [2];
  logic [15:0] lim_lo, lim_hi;
  logic pb_zero, bump1, bump2, cooling_choice;

  fts_mv_average u_avg1 (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .take_i(MV_STROBE_I & ~TRANSFER_O),
    .sample_i(MV1_I),
    .avg_o(avg1)
  );

  fts_mv_average u_avg2 (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .take_i(MV_STROBE_I & ~TRANSFER_O),
    .sample_i(MV2_I),
    .avg_o(avg2)
  );

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_incfg = incfg;
    next_o1cfg = o1cfg;
    next_o2cfg = o2cfg;
    next_splim = splim;
    next_acfg = acfg;
    next_sp_req = sp_req;
    next_shift_val = shift_val;
    lclr_c = 1'b0;
    if (WR_I)
    begin
      unique case (ADDR_I)
        OFS_CTRL:
        begin
          next_ctrl = {30'h0, WDATA_I[CTRL_CALIB_BIT], WDATA_I[CTRL_MANUAL_BIT]};
          lclr_c = WDATA_I[CTRL_LCLR_BIT];
        end
        OFS_INCFG: next_incfg = {24'h0, WDATA_I[7:0]};
        OFS_OUT1: next_o1cfg = WDATA_I;
        OFS_SECOND_OUTPUT_FUNCTION: next_o2cfg = WDATA_I;
        OFS_ALM1: next_acfg[0] = WDATA_I[8:0];
        OFS_ALM2: next_acfg[1] = WDATA_I[8:0];
        OFS_SPLIM: next_splim = WDATA_I;
        OFS_SP: next_sp_req = WDATA_I[15:0];
        OFS_SHIFT: next_shift_val = WDATA_I[15:0];
        default:
        begin
          next_ctrl = ctrl;
        end
      endcase
    end
    next_rdata = 32'h0000_0000;
    if (RD_I)
    begin
      unique case (ADDR_I)
        OFS_CTRL: next_rdata = ctrl;
        OFS_INCFG: next_rdata = incfg;
        OFS_OUT1: next_rdata = o1cfg;
        OFS_SECOND_OUTPUT_FUNCTION: next_rdata = o2cfg;
        OFS_ALM1: next_rdata = {23'h0, acfg[0]};
        OFS_ALM2: next_rdata = {23'h0, acfg[1]};
        OFS_SPLIM: next_rdata = splim;
        OFS_SP: next_rdata = {{16{SETPOINT_O[15]}}, SETPOINT_O};
        OFS_SHIFT: next_rdata = {{16{shift_val[15]}}, shift_val};
        OFS_STATUS: next_rdata = {23'h0, hide, alm, TRANSFER_O, FAIL_MODE_O,
                                  aderr, brk2, brk1};
        OFS_PV1: next_rdata = {{16{PV1_O[15]}}, PV1_O};
        OFS_MVAVG: next_rdata = {5'h0, avg2, 5'h0, avg1};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ctrl <= RST_CFG;
      incfg <= RST_CFG;
      o1cfg <= RST_CFG;
      o2cfg <= RST_CFG;
      splim <= RST_SPLIM;
      acfg[0] <= RST_CFG[8:0];
      acfg[1] <= RST_CFG[8:0];
      sp_req <= RST_SP;
      shift_val <= RST_SHIFT;
      RDATA_O <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      incfg <= next_incfg;
      o1cfg <= next_o1cfg;
      o2cfg <= next_o2cfg;
      splim <= next_splim;
      acfg <= next_acfg;
      sp_req <= next_sp_req;
      shift_val <= next_shift_val;
      RDATA_O <= next_rdata;
    end
  end

  // ----------------------------------------
  // Failure detection and transfer state
  // ----------------------------------------
  always_comb
  begin
    brk1_c = in_break(IN1_BREAK_I, incfg[IN_RNG1_LSB +: 2], IN1_SIGNAL_I);
    brk2_c = in_break(IN2_BREAK_I, incfg[IN_RNG2_LSB +: 2], IN2_SIGNAL_I);
    use1_c = incfg[IN_PVSEL_LSB +: 2] != PVS_TWO
             || incfg[IN_SPSEL_LSB +: 2] == SPS_ONE;
    use2_c = incfg[IN_PVSEL_LSB +: 2] != PVS_ONE
             || incfg[IN_SPSEL_LSB +: 2] == SPS_TWO;
    fail_c = (brk1_c && use1_c) || (brk2_c && use2_c) || ADC_FAIL_I;
    next_brk1 = brk1_c;
    next_brk2 = brk2_c;
    next_aderr = ADC_FAIL_I;
    next_fail = fail_c;
    next_pu_cnt = pu_cnt;
    next_state = state;
    unique case (state)
      ST_STARTUP:
      begin
        // Power start window holds the outputs in transfer
        next_pu_cnt = pu_cnt + 32'h1;
        if (pu_cnt == 32'(POWERUP_LEN - 1))
        begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (fail_c || ctrl[CTRL_MANUAL_BIT] || ctrl[CTRL_CALIB_BIT])
        begin
          next_state = ST_TRANSFER;
        end
      end
      ST_TRANSFER:
      begin
        if (!(fail_c || ctrl[CTRL_MANUAL_BIT] || ctrl[CTRL_CALIB_BIT]))
        begin
          next_state = ST_RUN;
        end
      end
    endcase
    next_xfer = next_state != ST_RUN;
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      state <= ST_STARTUP;
      pu_cnt <= 32'h0000_0000;
      brk1 <= 1'b0;
      brk2 <= 1'b0;
      aderr <= 1'b0;
      FAIL_MODE_O <= 1'b0;
      TRANSFER_O <= 1'b1;
    end
    else
    begin
      state <= next_state;
      pu_cnt <= next_pu_cnt;
      brk1 <= next_brk1;
      brk2 <= next_brk2;
      aderr <= next_aderr;
      FAIL_MODE_O <= next_fail;
      TRANSFER_O <= next_xfer;
    end
  end

  // ----------------------------------------
  // Control outputs, setpoint and process value
  // ----------------------------------------
  always_comb
  begin
    pb_zero = o1cfg[OUT_PB_LSB +: 16] == 16'h0000;
    bump1 = o1cfg[OUT_FAIL_LSB +: PCT_W] == FAIL_BUMPLESS;
    bump2 = o2cfg[OUT_FAIL_LSB +: PCT_W] == FAIL_BUMPLESS;
    cooling_choice = o2cfg[OUT_MODE_BIT];
    next_on1 = 1'b0;
    next_lvl1 = pct_clamp(MV1_I);
    if (pb_zero)
    begin
      // Transfer: direct action drives on, reverse drives off
      next_on1 = next_xfer ? o1cfg[OUT_MODE_BIT] : ONOFF_DEMAND_I;
      next_lvl1 = next_on1 ? PCT_MAX : 11'h000;
    end
    else if (next_xfer)
    begin
      // Open loop on the held average, or a fixed preset level
      next_lvl1 = bump1 ? avg1 : pct_clamp(o1cfg[OUT_FAIL_LSB +: PCT_W]);
    end
    next_lvl2 = pct_clamp(MV2_I);
    if (next_xfer && cooling_choice)
    begin
      next_lvl2 = bump2 ? avg2 : pct_clamp(o2cfg[OUT_FAIL_LSB +: PCT_W]);
    end
    lim_lo = splim[LIM_LOW_LSB +: 16];
    lim_hi = splim[LIM_HIGH_LSB +: 16];
    next_sp = sp_req;
    if ($signed(sp_req) < $signed(lim_lo))
    begin
      next_sp = lim_lo;
    end
    else if ($signed(sp_req) > $signed(lim_hi))
    begin
      next_sp = lim_hi;
    end
    // Saturate rather than wrap so a large offset cannot flip the sign
    pv_sum = {PV1_RAW_I[15], PV1_RAW_I} + {shift_val[15], shift_val};
    next_pv1 = pv_sum[15:0];
    if (pv_sum[16] != pv_sum[15])
    begin
      next_pv1 = pv_sum[16] ? 16'h8000 : 16'h7fff;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      OUT1_LEVEL_O <= 11'h000;
      OUT1_ON_O <= 1'b0;
      SECOND_OUTPUT_FUNCTION_LEVEL_O <= 11'h000;
      SETPOINT_O <= RST_SP;
      PV1_O <= 16'h0000;
    end
    else
    begin
      OUT1_LEVEL_O <= next_lvl1;
      OUT1_ON_O <= next_on1;
      SECOND_OUTPUT_FUNCTION_LEVEL_O <= next_lvl2;
      SETPOINT_O <= next_sp;
      PV1_O <= next_pv1;
    end
  end

  // ----------------------------------------
  // Alarm channels
  // ----------------------------------------
  always_comb
  begin
    cond_c = {ALARM2_COND_I, ALARM1_COND_I};
    next_armed = armed & ~{SP_REACHED_I, SP_REACHED_I};
    next_latched = latched;
    next_alm = alm;
    next_hide = hide;
    for (int i = 0; i < 2; i++)
    begin
      afn[i] = acfg[i][ALM_FN_LSB +: 4];
      abeh[i] = acfg[i][ALM_BEH_LSB +: 2];
      next_hide[i] = afn[i] == AF_SENSOR || afn[i] == AF_LOOP;
      // Failure mode already includes converter failure
      raw_c[i] = (afn[i] == AF_SENSOR) ? fail_c : cond_c[i];
      holdon_c[i] = armed[i] && afn[i] != AF_SENSOR
                    && (abeh[i] == AB_HOLD || abeh[i] == AB_LTHOLD);
      eff_c[i] = raw_c[i] && !holdon_c[i];
      latching_c[i] = abeh[i] == AB_LATCH || abeh[i] == AB_LTHOLD;
      // A new alarm in the clearing cycle keeps the latch set
      next_latched[i] = (eff_c[i] && latching_c[i])
                        || (latched[i] && !(lclr_c || EVENT_CLEAR_I));
      next_alm[i] = eff_c[i] || (latched[i] && latching_c[i]);
      if (fail_c && afn[i] != AF_DWELL)
      begin
        if (afn[i] == AF_LOOP || afn[i] == AF_SENSOR)
        begin
          next_alm[i] = 1'b1;
        end
        else
        begin
          next_alm[i] = acfg[i][ALM_FT_BIT];
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      armed <= 2'h3;
      latched <= 2'h0;
      alm <= 2'h0;
      hide <= 2'h0;
      ALARM1_O <= 1'b0;
      ALARM2_O <= 1'b0;
      HIDE1_O <= 1'b0;
      HIDE2_O <= 1'b0;
    end
    else
    begin
      armed <= next_armed;
      latched <= next_latched;
      alm <= next_alm;
      hide <= next_hide;
      ALARM1_O <= next_alm[0];
      ALARM2_O <= next_alm[1];
      HIDE1_O <= next_hide[0];
      HIDE2_O <= next_hide[1];
    end
  end
endmodule

// *** test/fts_supervisor_assertions.sv ***
// Purpose: Port-level checks on the failure transfer supervisor
// Assumes: One clock, asynchronous active-low reset
// Notes: Register contents are not visible here, so the checks lean on HIDE flags
`timescale 1ns/1ps
module fts_supervisor_assertions
  import fts_pkg::*;
#(
  parameter int unsigned POWERUP_LEN = 20
)
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic IN1_BREAK_I,
  input wire logic [15:0] IN1_SIGNAL_I,
  input wire logic IN2_BREAK_I,
  input wire logic [15:0] IN2_SIGNAL_I,
  input wire logic ADC_FAIL_I,
  input wire logic [10:0] OUT1_LEVEL_O,
  input wire logic OUT1_ON_O,
  input wire logic ALARM1_O,
  input wire logic ALARM2_O,
  input wire logic FAIL_MODE_O,
  input wire logic TRANSFER_O,
  input wire logic HIDE1_O,
  input wire logic HIDE2_O
);
  // ----------------------------------------
  // Power start counter
  // ----------------------------------------
  logic [31:0] up_cnt;
  logic [31:0] next_up_cnt;
  always_comb
  begin
    next_up_cnt = up_cnt;
    if (up_cnt < POWERUP_LEN)
    begin
      next_up_cnt = up_cnt + 32'h1;
    end
  end
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      up_cnt <= '0;
    end
    else
    begin
      up_cnt <= next_up_cnt;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_adc_fail; ADC_FAIL_I |=> FAIL_MODE_O; endproperty
  a_adc_fail: assert property (p_adc_fail)
    else $error("converter failure did not enter failure mode");
  property p_powerup; (up_cnt < POWERUP_LEN) |-> TRANSFER_O; endproperty
  a_powerup: assert property (p_powerup)
    else $error("transfer dropped inside power start window");
  property p_fail_xfer; FAIL_MODE_O |-> TRANSFER_O; endproperty
  a_fail_xfer: assert property (p_fail_xfer)
    else $error("failure mode without output transfer");
  // Clean inputs must never raise failure, whatever the selection
  property p_clean;
    (!IN1_BREAK_I && !IN2_BREAK_I && !ADC_FAIL_I && IN1_SIGNAL_I >= BREAK_UA
     && IN2_SIGNAL_I >= BREAK_UA) |=> !FAIL_MODE_O;
  endproperty
  a_clean: assert property (p_clean)
    else $error("failure mode with healthy inputs");
  property p_sens_on; $rose(FAIL_MODE_O) && HIDE1_O |-> ALARM1_O; endproperty
  a_sens_on: assert property (p_sens_on)
    else $error("sensor fail alarm one late");
  // Hide flag is judged in the alarm's own cycle, so a config write moves both together
  property p_adc_alarm; ADC_FAIL_I |=> !HIDE2_O || ALARM2_O; endproperty
  a_adc_alarm: assert property (p_adc_alarm)
    else $error("converter failure left alarm two off");
  property p_onoff; TRANSFER_O && OUT1_ON_O |-> OUT1_LEVEL_O == PCT_MAX; endproperty
  a_onoff: assert property (p_onoff)
    else $error("on-off output one level wrong in transfer");
  property p_level; TRANSFER_O |-> OUT1_LEVEL_O <= PCT_MAX; endproperty
  a_level: assert property (p_level)
    else $error("output one level above full scale in transfer");
  c_fail: cover property (FAIL_MODE_O);
  c_alarm: cover property ($rose(ALARM1_O));
  c_xfer_end: cover property ($fell(TRANSFER_O));
endmodule

bind fts_supervisor fts_supervisor_assertions #(.POWERUP_LEN(POWERUP_LEN)) u_chk (.*);

// *** test/fts_mv_source.sv ***
// Purpose: Model of the control loop that feeds manipulated values
// Assumes: Same clock as the supervisor
// Notes: New samples every eighth cycle, like a slow loop update
`timescale 1ns/1ps
module fts_mv_source
  import fts_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [10:0] mv1_set_i,
  input wire logic [10:0] mv2_set_i,
  output logic [10:0] mv1_o,
  output logic [10:0] mv2_o,
  output logic strobe_o
);
  logic [2:0] phase;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase <= 3'h0;
      mv1_o <= 11'h000;
      mv2_o <= 11'h000;
      strobe_o <= 1'b0;
    end
    else
    begin
      phase <= phase + 3'h1;
      strobe_o <= (phase == 3'h7);
      if (phase == 3'h7)
      begin
        // Values change only with the strobe, never between samples
        mv1_o <= (mv1_set_i > PCT_MAX) ? PCT_MAX : mv1_set_i;
        mv2_o <= (mv2_set_i > PCT_MAX) ? PCT_MAX : mv2_set_i;
      end
    end
  end
endmodule

// *** test/fts_supervisor_tb.sv ***
// Purpose: Self-checking bench for the failure transfer supervisor
// Assumes: Power start shortened to 20 cycles
// Notes: Fixed waits follow the one-cycle output latency of the hand-over
`timescale 1ns/1ps
module fts_supervisor_tb;
  import fts_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic brk1 = 1'b0, brk2 = 1'b0, adc = 1'b0, onoff = 1'b0, c1 = 1'b0, c2 = 1'b0;
  logic spr = 1'b0, evclr = 1'b0, stb, on1, al1, al2, fail, xfer, hd1, hd2;
  logic [15:0] sig1 = 16'h07d0, sig2 = 16'h07d0, pv_raw = 16'h0000, sp, pv1;
  logic [10:0] mv1s = 11'h12c, mv2s = 11'h064, mv1, mv2, lv1, lv2;
  int n_errors = 0, total_checks = 0;
  always #2 clk = ~clk;
  fts_mv_source u_src (.clk_i(clk), .resetn_i(rstn), .mv1_set_i(mv1s), .mv2_set_i(mv2s),
    .mv1_o(mv1), .mv2_o(mv2), .strobe_o(stb));
  fts_supervisor #(.POWERUP_LEN(20)) uut (.CLK_I(clk), .RESETN_I(rstn), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IN1_BREAK_I(brk1),
    .IN1_SIGNAL_I(sig1), .IN2_BREAK_I(brk2), .IN2_SIGNAL_I(sig2), .ADC_FAIL_I(adc),
    .PV1_RAW_I(pv_raw), .MV1_I(mv1), .MV2_I(mv2), .MV_STROBE_I(stb),
    .ONOFF_DEMAND_I(onoff), .ALARM1_COND_I(c1), .ALARM2_COND_I(c2), .SP_REACHED_I(spr),
    .EVENT_CLEAR_I(evclr), .OUT1_LEVEL_O(lv1), .OUT1_ON_O(on1), .SECOND_OUTPUT_FUNCTION_LEVEL_O(lv2),
    .ALARM1_O(al1), .ALARM2_O(al2), .FAIL_MODE_O(fail), .TRANSFER_O(xfer),
    .SETPOINT_O(sp), .PV1_O(pv1), .HIDE1_O(hd1), .HIDE2_O(hd2));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Drive sensor inputs, then judge failure mode and the three status flags
  task automatic sense(input logic [4:0] v, input logic ef, input logic [2:0] es);
    @(posedge clk);
    {brk1, brk2, adc} <= v[4:2];
    sig1 <= v[1] ? 16'h03e7 : 16'h03e8;
    sig2 <= v[0] ? 16'h00f9 : 16'h03e8;
    step(2);
    chk(fail, ef);
    rd_reg(OFS_STATUS, r);
    chk(r[2:0], es);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_powerup();
    step(1);
    chk(xfer, 1'b1);
    step(25);
    chk(xfer, 1'b0);
    rd_reg(OFS_SPLIM, r);
    chk(r, RST_SPLIM);
    rd_reg(8'hfc, r);
    chk(r, 32'h0);
  endtask
  task automatic t_clamp();
    logic [15:0] req [3] = '{16'h00c8, 16'hff9c, 16'h0007};
    logic [15:0] exp [3] = '{16'h0064, 16'hffce, 16'h0007};
    wr_reg(OFS_SPLIM, 32'h0064_ffce);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(OFS_SP, {16'h0, req[i]});
      step(3);
      chk(sp, exp[i]);
    end
  endtask
  task automatic t_shift();
    wr_reg(OFS_SHIFT, 32'h0000_ffdd);
    @(posedge clk);
    pv_raw <= 16'h00eb;
    step(3);
    chk(pv1, 16'h00c8);
  endtask
  task automatic t_sense();
    wr_reg(OFS_INCFG, 32'h90);
    sense(5'b00010, 1'b1, 3'b001);
    sense(5'b00001, 1'b0, 3'b010);
    sense(5'b01000, 1'b0, 3'b010);
    sense(5'b00100, 1'b1, 3'b100);
    wr_reg(OFS_INCFG, 32'h91);
    sense(5'b00001, 1'b1, 3'b010);
    wr_reg(OFS_INCFG, 32'h95);
    sense(5'b00010, 1'b1, 3'b001);
    wr_reg(OFS_INCFG, 32'h90);
    sense(5'b00000, 1'b0, 3'b000);
  endtask
  task automatic t_outputs();
    logic [10:0] h1, h2;
    step(500);
    wr_reg(OFS_OUT1, 32'h000a_01f4);
    wr_reg(OFS_SECOND_OUTPUT_FUNCTION, 32'h0000_10fa);
    wr_reg(OFS_CTRL, 32'h1);
    step(2);
    chk(xfer, 1'b1);
    chk(lv1, 11'h1f4);
    chk(lv2, 11'h0fa);
    wr_reg(OFS_CTRL, 32'h2);
    wr_reg(OFS_OUT1, 32'h0000_1000);
    step(2);
    chk({xfer, on1, lv1}, {2'b11, PCT_MAX});
    wr_reg(OFS_OUT1, 32'h0);
    step(2);
    chk(on1, 1'b0);
    wr_reg(OFS_OUT1, 32'h000a_07ff);
    wr_reg(OFS_SECOND_OUTPUT_FUNCTION, 32'h0000_17ff);
    step(2);
    h1 = lv1;
    h2 = lv2;
    chk(32'(h1 >= 11'h104 && h1 <= 11'h12c), 32'h1);
    chk(32'(h2 >= 11'h03c && h2 <= 11'h064), 32'h1);
    @(posedge clk);
    mv1s <= 11'h384;
    mv2s <= 11'h384;
    step(40);
    chk({lv1, lv2}, {h1, h2});
    wr_reg(OFS_CTRL, 32'h0);
    // Out of transfer the on-off output follows the controller demand again
    wr_reg(OFS_OUT1, 32'h0);
    onoff <= 1'b1;
    step(2);
    chk({xfer, on1, lv1}, {2'b01, PCT_MAX});
  endtask
  // Row: adc, cond two, event clear, expected alarm two, setpoint reached, config of alarm two
  task automatic t_alarms();
    logic [15:0] row [11] = '{16'h9100, 16'h8000, 16'h8103, 16'h9001, 16'h5000,
                              16'h0000, 16'h5010, 16'h1010, 16'h2010, 16'h4020, 16'h5820};
    wr_reg(OFS_ALM1, 32'h22);
    step(2);
    chk({hd1, al1}, 2'b10);
    for (int i = 0; i < 11; i++)
    begin
      wr_reg(OFS_ALM2, {23'h0, row[i][8:0]});
      @(posedge clk);
      {adc, c2, evclr} <= row[i][15:13];
      spr <= row[i][11];
      step(2);
      chk(al2, row[i][12]);
      chk(hd2, i == 3);
      if (i == 0)
        chk(al1, 1'b1);
    end
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_powerup();
    t_clamp();
    t_shift();
    t_sense();
    t_outputs();
    t_alarms();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule
